// ---- hdl/uar_defs.vh ----
// Constants for the asynchronous receive front end.
// Assumes inclusion by bare name from the design files under hdl/.
`ifndef UAR_DEFS_VH
`define UAR_DEFS_VH

// ----------------------------------------------------------------------
// Sampling
// ----------------------------------------------------------------------
`define UAR_SPB_NORMAL 5'h10
`define UAR_SPB_DOUBLE 5'h08
`define UAR_VOTE_FIRST_NORMAL 5'h08
`define UAR_VOTE_FIRST_DOUBLE 5'h04
`define UAR_DIV_W 12
`define UAR_DIV_RESET 12'h000

// ----------------------------------------------------------------------
// Frame format
// ----------------------------------------------------------------------
`define UAR_DBITS_MIN 4'h5
`define UAR_DBITS_MAX 4'hA
`define UAR_DATA_W 10

// ----------------------------------------------------------------------
// Receiver states
// ----------------------------------------------------------------------
`define UAR_ST_IDLE 2'h0
`define UAR_ST_START 2'h1
`define UAR_ST_DATA 2'h2
`define UAR_ST_STOP 2'h3

`endif

// ---- hdl/uar_buf2.v ----
// Two-entry valid/ready buffer that carries recovered frames.
// Assumes a single clock and a synchronous active-high reset.
`include "uar_defs.vh"

module uar_buf2 #(
  parameter W = 11
) (
  // Clock and reset
  input wire sys_clk,
  input wire rst,
  // Fill side
  input wire in_valid,
  output wire in_ready,
  input wire [W-1:0] in_data,
  // Drain side
  output wire out_valid,
  input wire out_ready,
  output wire [W-1:0] out_data
);

  reg [W-1:0] mem_ff [0:1];
  reg rd_ptr_ff;
  reg wr_ptr_ff;
  reg [1:0] cnt_ff;
  wire push;
  wire pop;

  assign in_ready = (cnt_ff != 2'h2);
  assign out_valid = (cnt_ff != 2'h0);
  assign out_data = mem_ff[rd_ptr_ff];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always @(posedge sys_clk) begin
    if (rst) begin
      rd_ptr_ff <= 1'b0;
      wr_ptr_ff <= 1'b0;
      cnt_ff <= 2'h0;
      mem_ff[0] <= {W{1'b0}};
      mem_ff[1] <= {W{1'b0}};
    end else begin
      if (push) begin
        mem_ff[wr_ptr_ff] <= in_data;
        wr_ptr_ff <= ~wr_ptr_ff;
      end
      if (pop)
        rd_ptr_ff <= ~rd_ptr_ff;
      if (push && !pop)
        cnt_ff <= cnt_ff + 2'h1;
      else if (pop && !push)
        cnt_ff <= cnt_ff - 2'h1;
    end
  end

endmodule

// ---- hdl/uar_rx.v ----
// Asynchronous serial receive front end: baud tick, start-bit
// qualification, three-sample majority recovery, frame delivery.
// Assumes the remote transmitter holds its rate within the stated range.
// Assumes frame_bits and double_speed_select hold while rx_busy is high.
//
// Operation
// - Sample line at 16x baud normally, 8x baud in double speed.
// - Double speed selected when double_speed_select is one.
// - Start detection begins on a high-to-low line transition.
// - Sample one is the first low sample after the fall.
// - Qualify start with samples 8,9,10 normal or 4,5,6 double.
// - Two or more high qualification samples reject start as noise.
// - Realign bit timing on every accepted start bit.
// - Sixteen or eight states per bit, each one sample number.
// - Data and parity bits decided by majority of centre samples.
// - Recover through the first stop bit, ignore further stop bits.
// - Normal and double: new start right after last stop vote.
// - Frames of five to ten data-plus-parity bits are handled.
// - Receiver and transmitter share the error budget equally.
// - Sample tick from integer division of system clock by divisor plus one.
`include "uar_defs.vh"

module uar_rx (
  // Clock and reset
  input wire sys_clk,
  input wire rst,
  // Serial line
  input wire serial_input_pin,
  // Configuration
  input wire double_speed_select,
  input wire [`UAR_DIV_W-1:0] baud_divisor,
  input wire [3:0] frame_bits,
  // Frame pulse, unbuffered
  output reg frame_valid,
  output reg [`UAR_DATA_W-1:0] frame_data,
  output reg frame_error_flag,
  // Buffered frame stream
  output wire rx_valid,
  input wire rx_ready,
  output wire [`UAR_DATA_W-1:0] rx_data,
  output wire rx_frame_error,
  // Status
  output wire rx_busy,
  output wire rx_overrun
);

  // --------------------------------------------------------------------
  // Synchroniser
  // --------------------------------------------------------------------
  // All three stages reset to the idle level, so no false fall follows
  // reset; line_ff is a third stage behind the two sync flops, prev_ff the edge memory
  reg sync1_ff;
  reg sync2_ff;
  reg line_ff;
  reg [`UAR_DIV_W-1:0] div_ff;
  reg tick_ff;

  always @(posedge sys_clk) begin
    if (rst) begin
      sync1_ff <= 1'b1;
      sync2_ff <= 1'b1;
      line_ff <= 1'b1;
    end else begin
      sync1_ff <= serial_input_pin;
      sync2_ff <= sync1_ff;
      line_ff <= sync2_ff;
    end
  end

  // --------------------------------------------------------------------
  // Baud tick
  // --------------------------------------------------------------------
  // Divide by divisor+1 so a divisor of zero ticks every clock; the
  // exact integer divide keeps the receiver's share of the rate error
  always @(posedge sys_clk) begin
    if (rst) begin
      div_ff <= `UAR_DIV_RESET;
      tick_ff <= 1'b0;
    end else if (div_ff == 12'h000) begin
      div_ff <= baud_divisor;
      tick_ff <= 1'b1;
    end else begin
      div_ff <= div_ff - 12'h001;
      tick_ff <= 1'b0;
    end
  end

  // --------------------------------------------------------------------
  // Mode-dependent sample positions
  // --------------------------------------------------------------------
  wire [4:0] spb;
  wire [4:0] vote_a;
  wire [4:0] vote_c;
  wire [3:0] nbits;

  // Mode is read live: a change while busy would skew the frame in
  // flight, so the select must be held between frames
  assign spb = double_speed_select ? `UAR_SPB_DOUBLE :
               `UAR_SPB_NORMAL;
  assign vote_a = double_speed_select ? `UAR_VOTE_FIRST_DOUBLE :
                  `UAR_VOTE_FIRST_NORMAL;
  assign vote_c = vote_a + 5'h02;
  // Out-of-range sizes are clamped rather than left to run wild
  // The size is taken only while idle, through nbits_ff
  assign nbits = (frame_bits < `UAR_DBITS_MIN) ? `UAR_DBITS_MIN :
                 (frame_bits > `UAR_DBITS_MAX) ? `UAR_DBITS_MAX :
                 frame_bits;

  // --------------------------------------------------------------------
  // Recovery state machine
  // --------------------------------------------------------------------
  reg [1:0] state_ff;
  reg [4:0] samp_ff;
  reg [1:0] highs_ff;
  reg [3:0] bit_ff;
  reg [3:0] nbits_ff;
  reg [`UAR_DATA_W-1:0] shift_ff;
  reg prev_ff;
  reg [1:0] nxt_state;
  reg [4:0] nxt_samp;
  reg [1:0] nxt_highs;
  reg [3:0] nxt_bit;
  reg [`UAR_DATA_W-1:0] nxt_shift;
  reg done;
  reg stop_bad;
  reg voted;
  reg in_vote;
  reg [1:0] highs_now;

  wire fall;
  wire buf_ready;

  assign fall = prev_ff && !line_ff;

  // Positions that close a vote and close a bit period
  wire at_vote_end;
  wire at_bit_end;
  wire at_last_data;

  assign at_vote_end = (samp_ff == vote_c);
  assign at_bit_end = (samp_ff == spb);
  // Frame size is held from idle so a mid-frame change cannot cut it
  assign at_last_data = (bit_ff + 4'h1 == nbits_ff);

  always @* begin
    nxt_state = state_ff;
    nxt_samp = samp_ff;
    nxt_highs = highs_ff;
    nxt_bit = bit_ff;
    nxt_shift = shift_ff;
    done = 1'b0;
    stop_bad = 1'b0;
    in_vote = (samp_ff >= vote_a) && (samp_ff <= vote_c);
    highs_now = highs_ff + {1'b0, line_ff};
    voted = highs_now[1];
    if (tick_ff) begin
      case (state_ff)
        `UAR_ST_IDLE: begin
          // Idle samples are not numbered; first low one is sample 1
          if (fall) begin
            nxt_state = `UAR_ST_START;
            nxt_samp = 5'h02;
            nxt_highs = 2'h0;
          end
        end
        `UAR_ST_START: begin
          if (in_vote)
            nxt_highs = highs_now;
          nxt_samp = samp_ff + 5'h01;
          if (at_vote_end) begin
            if (voted) begin
              nxt_state = `UAR_ST_IDLE;
            end else begin
              // Timing now counts from this start bit's centre, so drift
              // cannot build up from one frame to the next
              nxt_state = `UAR_ST_DATA;
              nxt_samp = vote_c + 5'h01;
              nxt_bit = 4'h0;
              nxt_highs = 2'h0;
            end
          end
        end
        `UAR_ST_DATA: begin
          if (in_vote)
            nxt_highs = highs_now;
          nxt_samp = at_bit_end ? 5'h01 : samp_ff + 5'h01;
          if (at_vote_end) begin
            nxt_shift = {voted, shift_ff[`UAR_DATA_W-1:1]};
            nxt_highs = 2'h0;
            nxt_bit = bit_ff + 4'h1;
            if (at_last_data)
              nxt_state = `UAR_ST_STOP;
          end
        end
        `UAR_ST_STOP: begin
          if (in_vote)
            nxt_highs = highs_now;
          nxt_samp = at_bit_end ? 5'h01 : samp_ff + 5'h01;
          if (at_vote_end) begin
            // Only the first stop bit is examined
            done = 1'b1;
            stop_bad = !voted;
            nxt_state = `UAR_ST_IDLE;
            nxt_highs = 2'h0;
          end
        end
        default: begin
          nxt_state = `UAR_ST_IDLE;
        end
      endcase
    end
  end

  // Edge memory only advances on ticks; in double speed the stop vote
  // ends at sample 6, so a fall at or before that sample is not taken as a start.
  always @(posedge sys_clk) begin
    if (rst) begin
      state_ff <= `UAR_ST_IDLE;
      samp_ff <= 5'h00;
      highs_ff <= 2'h0;
      bit_ff <= 4'h0;
      nbits_ff <= `UAR_DBITS_MAX;
      shift_ff <= {`UAR_DATA_W{1'b0}};
      prev_ff <= 1'b1;
    end else begin
      state_ff <= nxt_state;
      samp_ff <= nxt_samp;
      highs_ff <= nxt_highs;
      bit_ff <= nxt_bit;
      shift_ff <= nxt_shift;
      if (tick_ff)
        prev_ff <= line_ff;
      if (tick_ff && state_ff == `UAR_ST_IDLE)
        nbits_ff <= nbits;
    end
  end

  // --------------------------------------------------------------------
  // Frame delivery
  // --------------------------------------------------------------------
  reg overrun_ff;
  wire [`UAR_DATA_W-1:0] aligned;
  wire [`UAR_DATA_W:0] buf_in;
  wire [`UAR_DATA_W:0] buf_out;

  // Shift in from the top, then right-justify to the frame size
  assign aligned = shift_ff >> (4'hA - nbits_ff);

  always @(posedge sys_clk) begin
    if (rst) begin
      frame_valid <= 1'b0;
      frame_data <= {`UAR_DATA_W{1'b0}};
      frame_error_flag <= 1'b0;
    end else begin
      frame_valid <= done;
      if (done) begin
        frame_data <= aligned;
        frame_error_flag <= stop_bad;
      end
    end
  end

  // --------------------------------------------------------------------
  // Two-entry buffer
  // --------------------------------------------------------------------
  // Error status rides in the top bit so it never parts from its word
  assign buf_in = {frame_error_flag, frame_data};

  uar_buf2 #(
    .W(`UAR_DATA_W + 1)
  ) uar_buf2_inst (
    .sys_clk(sys_clk),
    .rst(rst),
    .in_valid(frame_valid),
    .in_ready(buf_ready),
    .in_data(buf_in),
    .out_valid(rx_valid),
    .out_ready(rx_ready),
    .out_data(buf_out)
  );

  assign rx_data = buf_out[`UAR_DATA_W-1:0];
  assign rx_frame_error = buf_out[`UAR_DATA_W];

  // --------------------------------------------------------------------
  // Status
  // --------------------------------------------------------------------
  // Sticky: a frame meeting a full buffer is dropped and noted; only
  // reset clears it, so a late reader still learns of the loss
  always @(posedge sys_clk) begin
    if (rst) begin
      overrun_ff <= 1'b0;
    end else if (frame_valid && !buf_ready) begin
      overrun_ff <= 1'b1;
    end
  end

  assign rx_busy = (state_ff != `UAR_ST_IDLE);
  assign rx_overrun = overrun_ff;

endmodule

// ---- tb/uar_rx_props.sv ----
// Checker on the ports of uar_rx.
// Assumes configuration stays stable while a frame is in flight.
`include "uar_defs.vh"
module uar_rx_props (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Line and setup
  input wire logic serial_input_pin,
  input wire logic double_speed_select,
  input wire logic [`UAR_DIV_W-1:0] baud_divisor,
  input wire logic [3:0] frame_bits,
  // Results
  input wire logic frame_valid,
  input wire logic [`UAR_DATA_W-1:0] frame_data,
  input wire logic frame_error_flag,
  input wire logic rx_valid,
  input wire logic rx_ready,
  input wire logic [`UAR_DATA_W-1:0] rx_data,
  input wire logic rx_frame_error,
  input wire logic rx_busy,
  input wire logic rx_overrun
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----
  // Frame age since busy rose, line high time
  // ----
  logic busy_ff;
  logic [15:0] age_ff, low_age_ff, bit_len, lo;
  assign bit_len = (double_speed_select ? 16'h0008 : 16'h0010) *
                   ({4'h0, baud_divisor} + 16'h0001);
  assign lo = ({12'h000, frame_bits} + 16'h0001) * bit_len;
  always_ff @(posedge sys_clk) begin
    busy_ff <= rx_busy;
    age_ff <= (rx_busy && !busy_ff) ? 16'h0001 : age_ff + 16'h0001;
    low_age_ff <= serial_input_pin ?
                  low_age_ff + {15'h0000, ~&low_age_ff} : 16'h0000;
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  chk_valid_pulse: assert property (frame_valid |=> !frame_valid)
    else $error("frame pulse longer than one cycle");
  chk_frame_timing: assert property (frame_valid |->
    age_ff >= lo && age_ff < lo + bit_len)
    else $error("frame delivered at wrong time");
  chk_start_fall: assert property ($rose(rx_busy) |->
    low_age_ff <= {4'h0, baud_divisor} + 16'h0006)
    else $error("busy without a recent line fall");
  chk_buffer_fill: assert property (frame_valid |=> rx_valid)
    else $error("frame not buffered");
  chk_head_hold: assert property (rx_valid && !rx_ready |=>
    rx_valid && $stable(rx_data) && $stable(rx_frame_error))
    else $error("buffer head changed while stalled");
  chk_overrun_sticky: assert property (rx_overrun |=> rx_overrun)
    else $error("overrun cleared without reset");
  chk_data_hold: assert property (!frame_valid |-> $stable(frame_data))
    else $error("frame data changed between frames");
  chk_reset_quiet: assert property (disable iff (1'b0) rst |=>
    !frame_valid && !rx_valid && !rx_busy && !rx_overrun)
    else $error("outputs active after reset");
  cover property (frame_valid && frame_error_flag);
  cover property (frame_valid && double_speed_select);
  cover property ($rose(rx_overrun));
endmodule
bind uar_rx uar_rx_props uar_rx_props_inst (.sys_clk, .rst,
  .serial_input_pin, .double_speed_select, .baud_divisor, .frame_bits,
  .frame_valid, .frame_data, .frame_error_flag, .rx_valid, .rx_ready,
  .rx_data, .rx_frame_error, .rx_busy, .rx_overrun);

// ---- tb/uar_tx_model.sv ----
// Remote transmitter driving the receive line.
// Assumes go is pulsed for one clock while busy is low.
module uar_tx_model (
  // Clock
  input wire logic sys_clk,
  // Command
  input wire logic go,
  input wire logic [9:0] word,
  input wire logic [3:0] nbits,
  input wire logic [15:0] bit_clks,
  input wire logic stop_val,
  input wire logic [15:0] glitch_clks,
  // Line
  output logic line,
  output logic busy
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    line = 1'b1;
    busy = 1'b0;
  end
  // Line idles high between frames, as a pulled-up wire would
  always @(posedge sys_clk) begin
    if (go && !busy) begin
      busy <= 1'b1;
      line <= 1'b0;
      if (glitch_clks != 16'h0000) begin
        repeat (glitch_clks) @(posedge sys_clk);
      end else begin
        repeat (bit_clks) @(posedge sys_clk);
        for (int i = 0; i < nbits; i++) begin
          line <= word[i];
          repeat (bit_clks) @(posedge sys_clk);
        end
        line <= stop_val;
        repeat (bit_clks) @(posedge sys_clk);
      end
      line <= 1'b1;
      // A low stop bit is a break; give one idle bit before the next
      // start so the receiver sees a fresh falling edge
      if (!stop_val)
        repeat (bit_clks) @(posedge sys_clk);
      busy <= 1'b0;
    end
  end
endmodule

// ---- tb/uar_rx_bench.sv ----
// Bench for uar_rx with a transmitter model on the line.
// Assumes a divisor of 3: four clocks per sample.
module uar_rx_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk, rst, line, dss, go, stop_val, rx_ready, tx_busy;
  logic frame_valid, frame_error_flag, rx_valid, rx_frame_error;
  logic rx_busy, rx_overrun;
  logic [11:0] div;
  logic [3:0] nbits;
  logic [9:0] word, frame_data, rx_data;
  logic [15:0] bit_clks, glitch;
  int fail_count, compares;
  uar_rx uar_rx_inst (.sys_clk, .rst, .serial_input_pin(line),
    .double_speed_select(dss), .baud_divisor(div), .frame_bits(nbits),
    .frame_valid, .frame_data, .frame_error_flag, .rx_valid, .rx_ready,
    .rx_data, .rx_frame_error, .rx_busy, .rx_overrun);
  uar_tx_model uar_tx_model_inst (.sys_clk, .go, .word, .nbits,
    .bit_clks, .stop_val, .glitch_clks(glitch), .line, .busy(tx_busy));
  always #50 sys_clk = ~sys_clk;
  // ----
  // Compares and frame traffic
  // ----
  task automatic check10(input logic [9:0] got, input logic [9:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic check1(input logic got, input logic exp);
    check10({9'h000, got}, {9'h000, exp});
  endtask
  task automatic frame(input logic [9:0] w, input logic [3:0] n,
                       input logic [15:0] bc, input logic sv);
    int k;
    logic [9:0] exp;
    exp = w & ((10'h001 << n) - 10'h001);
    word = w;
    nbits = n;
    bit_clks = bc;
    stop_val = sv;
    go = 1'b1;
    @(negedge sys_clk);
    go = 1'b0;
    for (k = 0; k < 3000 && frame_valid !== 1'b1; k++) @(negedge sys_clk);
    check1(frame_valid, 1'b1);
    check10(frame_data, exp);
    check1(frame_error_flag, ~sv);
    @(negedge sys_clk);
    if (rx_ready) begin
      check1(rx_valid, 1'b1);
      check10(rx_data, exp);
      check1(rx_frame_error, ~sv);
    end
    while (tx_busy) @(negedge sys_clk);
  endtask
  task automatic report_and_stop;
    $display("Compares %0d, mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // Noise spike of three samples, then a real frame must still land
  task automatic t_noise;
    int k, seen, busy_seen;
    seen = 0;
    busy_seen = 0;
    glitch = 16'h000C;
    go = 1'b1;
    @(negedge sys_clk);
    go = 1'b0;
    glitch = 16'h0000;
    for (k = 0; k < 200; k++) begin
      @(negedge sys_clk);
      seen += frame_valid;
      busy_seen += rx_busy;
    end
    check1(busy_seen != 0, 1'b1);
    check1(seen != 0, 1'b0);
    check1(rx_busy, 1'b0);
    frame(10'h0C3, 4'h8, 16'h0040, 1'b1);
  endtask
  // Stalled reader: two frames fit, the third overruns
  task automatic t_buffer;
    rx_ready = 1'b0;
    frame(10'h011, 4'h8, 16'h0040, 1'b1);
    frame(10'h022, 4'h8, 16'h0040, 1'b0);
    frame(10'h033, 4'h8, 16'h0040, 1'b1);
    check1(rx_overrun, 1'b1);
    check1(rx_valid, 1'b1);
    check10(rx_data, 10'h011);
    rx_ready = 1'b1;
    @(negedge sys_clk);
    check10(rx_data, 10'h022);
    check1(rx_frame_error, 1'b1);
    @(negedge sys_clk);
    check1(rx_valid, 1'b0);
  endtask
  initial begin
    sys_clk = 1'b0;
    rst = 1'b1;
    dss = 1'b0;
    go = 1'b0;
    stop_val = 1'b1;
    rx_ready = 1'b1;
    div = 12'h003;
    nbits = 4'h8;
    word = 10'h000;
    bit_clks = 16'h0040;
    glitch = 16'h0000;
    repeat (3) @(negedge sys_clk);
    rst = 1'b0;
    for (int n = 5; n <= 10; n++)
      frame(10'h2B5, 4'(n), 16'h0040, 1'b1);
    frame(10'h1A5, 4'h9, 16'h0042, 1'b1);
    frame(10'h15A, 4'h9, 16'h003E, 1'b1);
    frame(10'h0F0, 4'h8, 16'h0040, 1'b0);
    frame(10'h00F, 4'h8, 16'h0040, 1'b1);
    dss = 1'b1;
    frame(10'h0A5, 4'h8, 16'h0021, 1'b1);
    frame(10'h05A, 4'h8, 16'h001F, 1'b1);
    dss = 1'b0;
    t_noise;
    t_buffer;
    report_and_stop;
  end
  initial begin
    repeat (40000) @(posedge sys_clk);
    fail_count++;
    report_and_stop;
  end
endmodule
